// file: rtl/mstf_defs.vh
// Constants for the stripe track record formatter
`ifndef MSTF_DEFS_VH
`define MSTF_DEFS_VH

// ==========================================================
// Register offsets (byte addresses)
`define MSTF_CTRL_OFS       8'h00
`define MSTF_CONFIG_OFS     8'h04
`define MSTF_T1_SENT_OFS    8'h08
`define MSTF_T2_SENT_OFS    8'h0c
`define MSTF_STATUS_OFS     8'h10
`define MSTF_FAILCNT_OFS    8'h14
`define MSTF_IRQ_STATUS_OFS 8'h18
`define MSTF_IRQ_CLEAR_OFS  8'h1c
`define MSTF_IRQ_ENABLE_OFS 8'h20

// ==========================================================
// Control register fields
`define MSTF_CTRL_START_BIT  0
`define MSTF_CTRL_MASK_LSB   1
`define MSTF_CTRL_CANCEL_BIT 3

// ==========================================================
// Sentinel register defaults: {alt end, primary end, alt start, primary start}
`define MSTF_T1_SENT_RST 32'h1f1f0505
`define MSTF_T2_SENT_RST 32'h0c0f0d0b
`define MSTF_CONFIG_RST  32'h00000000

// ==========================================================
// Character shapes: bits per character, parity included
`define MSTF_T1_BPC 3'h7
`define MSTF_T2_BPC 3'h5

// ==========================================================
// Status byte fields
`define MSTF_ST_BLANK_BIT 7
`define MSTF_ST_BAD_BIT   6
`define MSTF_ST_TRK1_BIT  2
`define MSTF_ST_TRK2_BIT  1

// ==========================================================
// Interrupt event bits
`define MSTF_IRQ_DONE_BIT 0
`define MSTF_IRQ_FAIL_BIT 1

`endif

// file: rtl/mstf_formatter.v
// Stripe track record formatter: decode, check, buffer and emit track records
// How it works
// - Per track: length, status, data; tracks consecutive
// - Valid length counts status plus data bytes
// - Invalid track: length one, status only
// - Status bit 7: no start sentinel, blank
// - Status bit 6: parity, LRC or end error
// - Status bits 5..3 and 0 driven zero
// - Bit 2 first track, bit 1 second
// - Data keeps sentinels, drops the LRC character
// - One byte per decoded character value
// - Either start sentinel, either end sentinel accepted
// - Single track: data only if valid, else retry
// - Stay armed after failure until success or cancel
// - Count failures, readable on request
// - Retry lit until success or cancel
// - All-tracks mode fails if any track fails
// - Any-one mode succeeds with one valid track
`include "mstf_defs.vh"
`default_nettype none
module mstf_formatter (
  input wire core_clk,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Reader head, asynchronous to core_clk
  input wire [6:0] head_char,
  input wire head_trk,
  input wire head_char_tgl,
  input wire head_swipe_tgl,
  // Record byte stream towards the host
  output reg rec_valid,
  output reg [7:0] rec_data,
  input wire rec_ready,
  // Operator retry lamp and interrupt
  output reg retry_lamp,
  output wire irq
);
  // ==========================================================
  // States
  localparam ST_IDLE = 3'h0;
  localparam ST_ARMED = 3'h1;
  localparam ST_EVAL = 3'h2;
  localparam ST_LEN = 3'h3;
  localparam ST_STAT = 3'h4;
  localparam ST_DATA = 3'h5;
  reg [2:0] state;
  reg [1:0] track_read_request;
  reg [6:0] rd_idx;
  reg [15:0] fail_cnt;
  reg [31:0] config_reg, t1_sent, t2_sent;
  reg [1:0] irq_status, irq_enable;
  reg cur_trk, ev_done, ev_fail, dec_clear;
  reg [5:0] mem [0:255];
  wire [1:0] trk_found, trk_valid, trk_store;
  wire [13:0] trk_cnt, trk_char;
  wire multitrack_mode_select = config_reg[0];

  // ==========================================================
  // Head synchroniser: two flops, toggles edge-detected on the second
  reg [9:0] head_s1, head_s2;
  reg [1:0] tgl_s3;
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      head_s1 <= 10'h000;
      head_s2 <= 10'h000;
      tgl_s3 <= 2'h0;
    end
    else
    begin
      head_s1 <= {head_swipe_tgl, head_char_tgl, head_trk, head_char};
      head_s2 <= head_s1;
      tgl_s3 <= head_s2[9:8];
    end
  end
  // Head data must be stable before its toggle flips; both take the same path
  wire [6:0] h_char = head_s2[6:0];
  wire h_trk = head_s2[7];
  wire char_evt = (head_s2[8] ^ tgl_s3[0]) && (state == ST_ARMED);
  wire swipe_evt = (head_s2[9] ^ tgl_s3[1]) && (state == ST_ARMED);

  // ==========================================================
  // Per-track decoders
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : trk
      wire [2:0] bpc = (g == 0) ? `MSTF_T1_BPC : `MSTF_T2_BPC;
      wire [6:0] dmask = (7'h01 << (bpc - 3'h1)) - 7'h01;
      wire [6:0] pmask = {dmask[5:0], 1'b1};
      wire [31:0] sent = (g == 0) ? t1_sent : t2_sent;
      wire [6:0] data = h_char & dmask;
      wire par_ok = ^(h_char & pmask); // Odd character parity
      wire is_start = (data == ({1'b0, sent[5:0]} & dmask)) ||
                      (data == ({1'b0, sent[13:8]} & dmask));
      wire is_end = (data == ({1'b0, sent[21:16]} & dmask)) ||
                    (data == ({1'b0, sent[29:24]} & dmask));
      wire hit = char_evt && (h_trk == g);
      reg [1:0] phase;
      reg found, err;
      reg [6:0] lrc, cnt;
      // Hunt, collect, check the LRC, then ignore trailing bits
      always @(posedge core_clk)
      begin
        if (sys_rst || dec_clear)
        begin
          phase <= 2'h0;
          found <= 1'b0;
          err <= 1'b0;
          lrc <= 7'h00;
          cnt <= 7'h00;
        end
        else if (hit)
        begin
          case (phase)
            2'h0:
            begin
              // Leading clocking zeros are skipped until a start sentinel
              if (is_start && par_ok)
              begin
                found <= 1'b1;
                lrc <= data;
                cnt <= 7'h01;
                phase <= 2'h1;
              end
            end
            2'h1:
            begin
              lrc <= lrc ^ data;
              if (!par_ok || cnt == 7'h7f)
                err <= 1'b1;
              if (cnt != 7'h7f)
                cnt <= cnt + 7'h01;
              if (is_end)
                phase <= 2'h2;
            end
            2'h2:
            begin
              // Even LRC: its data bits equal the running XOR
              if (data != lrc || !par_ok)
                err <= 1'b1;
              phase <= 2'h3;
            end
            default:
              phase <= phase;
          endcase
        end
      end
      assign trk_found[g] = found;
      // A missing end sentinel or LRC is reported as a bad track
      assign trk_valid[g] = found && !err && (phase == 2'h3);
      assign trk_store[g] = hit && ((phase == 2'h0 && is_start && par_ok) ||
                                    (phase == 2'h1 && cnt != 7'h7f));
      assign trk_cnt[g * 7 +: 7] = cnt;
      assign trk_char[g * 7 +: 7] = data; // Parity bit dropped
    end
  endgenerate
  // ==========================================================
  // Character buffer: one entry per decoded character, LRC never stored
  wire [6:0] wr_idx = h_trk ? trk_cnt[13:7] : trk_cnt[6:0];
  // Masked value: neither track's parity bit reaches the stored bits
  wire [6:0] wr_char = h_trk ? trk_char[13:7] : trk_char[6:0];
  always @(posedge core_clk)
  begin
    if (trk_store[h_trk])
      mem[{h_trk, wr_idx}] <= wr_char[5:0];
  end
  // ==========================================================
  // Record sequencing
  wire [6:0] cur_cnt = cur_trk ? trk_cnt[13:7] : trk_cnt[6:0];
  wire cur_valid = trk_valid[cur_trk];
  wire [1:0] req_valid = trk_valid & track_read_request;
  wire req_ok = multitrack_mode_select ? (req_valid != 2'h0) :
                (req_valid == track_read_request);
  wire slot = !rec_valid || rec_ready;
  wire ctrl_wr = reg_wr && (reg_addr == `MSTF_CTRL_OFS);
  wire start_wr = ctrl_wr && reg_wdata[`MSTF_CTRL_START_BIT];
  wire cancel_read_request = ctrl_wr && reg_wdata[`MSTF_CTRL_CANCEL_BIT];
  wire [1:0] wr_mask = reg_wdata[`MSTF_CTRL_MASK_LSB +: 2];
  wire [7:0] status_byte = {!trk_found[cur_trk],
                            trk_found[cur_trk] && !cur_valid,
                            3'h0, !cur_trk, cur_trk, 1'b0};
  // Main sequencer; cancel only acts while waiting for a swipe
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      track_read_request <= 2'h0;
      cur_trk <= 1'b0;
      rd_idx <= 7'h00;
      fail_cnt <= 16'h0000;
      retry_lamp <= 1'b0;
      rec_valid <= 1'b0;
      rec_data <= 8'h00;
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      dec_clear <= 1'b1;
    end
    else
    begin
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      dec_clear <= 1'b0;
      if (rec_ready)
        rec_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start_wr && wr_mask != 2'h0)
          begin
            track_read_request <= wr_mask;
            dec_clear <= 1'b1;
            state <= ST_ARMED;
          end
        end
        ST_ARMED:
        begin
          if (cancel_read_request)
          begin
            retry_lamp <= 1'b0;
            dec_clear <= 1'b1;
            state <= ST_IDLE;
          end
          else if (swipe_evt)
            state <= ST_EVAL;
        end
        ST_EVAL:
        begin
          if (req_ok)
          begin
            retry_lamp <= 1'b0;
            cur_trk <= !track_read_request[0];
            state <= ST_LEN;
          end
          else
          begin
            // Stay armed for the next swipe, no data leaves
            retry_lamp <= 1'b1;
            fail_cnt <= fail_cnt + 16'h0001;
            ev_fail <= 1'b1;
            dec_clear <= 1'b1;
            state <= ST_ARMED;
          end
        end
        ST_LEN:
        begin
          if (slot)
          begin
            rec_valid <= 1'b1;
            rec_data <= cur_valid ? {1'b0, cur_cnt} + 8'h01 : 8'h01;
            state <= ST_STAT;
          end
        end
        ST_STAT:
        begin
          if (slot)
          begin
            rec_valid <= 1'b1;
            rec_data <= status_byte;
            rd_idx <= 7'h00;
            if (cur_valid)
              state <= ST_DATA;
            else if (!cur_trk && track_read_request[1])
            begin
              cur_trk <= 1'b1;
              state <= ST_LEN;
            end
            else
            begin
              ev_done <= 1'b1;
              dec_clear <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        ST_DATA:
        begin
          if (slot)
          begin
            rec_valid <= 1'b1;
            rec_data <= {2'h0, mem[{cur_trk, rd_idx}]};
            rd_idx <= rd_idx + 7'h01;
            if (rd_idx == cur_cnt - 7'h01)
            begin
              if (!cur_trk && track_read_request[1])
              begin
                cur_trk <= 1'b1;
                state <= ST_LEN;
              end
              else
              begin
                ev_done <= 1'b1;
                dec_clear <= 1'b1;
                state <= ST_IDLE;
              end
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Writable registers and sticky interrupt status
  wire clr_wr = reg_wr && (reg_addr == `MSTF_IRQ_CLEAR_OFS);
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      config_reg <= `MSTF_CONFIG_RST;
      t1_sent <= `MSTF_T1_SENT_RST;
      t2_sent <= `MSTF_T2_SENT_RST;
      irq_enable <= 2'h0;
      irq_status <= 2'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == `MSTF_CONFIG_OFS)
        config_reg <= {31'h00000000, reg_wdata[0]};
      if (reg_wr && reg_addr == `MSTF_T1_SENT_OFS)
        t1_sent <= reg_wdata;
      if (reg_wr && reg_addr == `MSTF_T2_SENT_OFS)
        t2_sent <= reg_wdata;
      if (reg_wr && reg_addr == `MSTF_IRQ_ENABLE_OFS)
        irq_enable <= reg_wdata[1:0];
      // A new event wins over a clear in the same cycle
      irq_status <= (irq_status & ~(clr_wr ? reg_wdata[1:0] : 2'h0)) |
                    {ev_fail, ev_done};
    end
  end
  assign irq = |(irq_status & irq_enable);

  // ==========================================================
  // Read data, one cycle after the strobe and only then
  always @(posedge core_clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `MSTF_CONFIG_OFS: reg_rdata <= config_reg;
        `MSTF_T1_SENT_OFS: reg_rdata <= t1_sent;
        `MSTF_T2_SENT_OFS: reg_rdata <= t2_sent;
        `MSTF_STATUS_OFS: reg_rdata <= {23'h000000, trk_found, trk_valid,
                                         state, retry_lamp, state != ST_IDLE};
        `MSTF_FAILCNT_OFS: reg_rdata <= {16'h0000, fail_cnt};
        `MSTF_IRQ_STATUS_OFS: reg_rdata <= {30'h00000000, irq_status};
        `MSTF_IRQ_ENABLE_OFS: reg_rdata <= {30'h00000000, irq_enable};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end
endmodule // mstf_formatter

`default_nettype wire

// file: tb/mstf_formatter_properties.sv
// Checker for the record stream and retry lamp of the track record formatter
`include "mstf_defs.vh"
`default_nettype none
module mstf_formatter_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic rec_valid,
  input wire logic [7:0] rec_data,
  input wire logic rec_ready,
  input wire logic retry_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stat_nx;
  logic [7:0] rem;
  wire logic take = rec_valid && rec_ready;
  wire logic is_stat = take && stat_nx;
  wire logic cancel_wr = reg_wr && reg_addr == `MSTF_CTRL_OFS &&
    reg_wdata[`MSTF_CTRL_CANCEL_BIT];
  // ==========================================================
  // Record position: length, then status, then the data it counts
  always @(posedge core_clk)
    if (sys_rst)
    begin
      rem <= 8'h00;
      stat_nx <= 1'b0;
    end
    else if (take)
    begin
      if (stat_nx)
        stat_nx <= 1'b0;
      else if (rem == 8'h00)
      begin
        rem <= rec_data - 8'h01;
        stat_nx <= 1'b1;
      end
      else
        rem <= rem - 8'h01;
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_HOLD: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
    else $error("record byte changed before it was taken");
  AST_ERR_LEN: assert property (is_stat && rec_data[7:6] != 2'b00 |-> rem == 8'h00)
    else $error("failed track carried data");
  AST_OK_LEN: assert property (is_stat && rec_data[7:6] == 2'b00 |-> rem >= 8'h02)
    else $error("valid track shorter than both sentinels");
  AST_RSVD: assert property (is_stat |-> rec_data[5:3] == 3'h0 && !rec_data[0])
    else $error("reserved status bits set");
  AST_TRK: assert property (is_stat |-> rec_data[2] != rec_data[1])
    else $error("status names no single track");
  AST_REASON: assert property (is_stat |-> !(rec_data[7] && rec_data[6]))
    else $error("blank and bad flagged together");
  AST_LAMP_QUIET: assert property ($rose(retry_lamp) |-> !rec_valid [*4])
    else $error("data sent on a failed read");
  AST_LAMP_OFF: assert property ($fell(retry_lamp) |->
    ($past(cancel_wr) || $past(cancel_wr, 2)) or (##[0:3] rec_valid))
    else $error("lamp went out without success or cancel");
endmodule // mstf_formatter_properties
bind mstf_formatter mstf_formatter_properties chk_u (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .rec_valid(rec_valid),
  .rec_data(rec_data), .rec_ready(rec_ready), .retry_lamp(retry_lamp)
);
`default_nettype wire

// file: tb/mstf_head_model.sv
// Stripe reader head model: characters with parity, check character, swipe end
`default_nettype none
module mstf_head_model (
  input wire logic core_clk,
  output logic [6:0] head_char,
  output logic head_trk,
  output logic head_char_tgl,
  output logic head_swipe_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet head at time zero
  initial
  begin
    head_char = 7'h00;
    head_trk = 1'b0;
    head_char_tgl = 1'b0;
    head_swipe_tgl = 1'b0;
  end
  // One character, odd parity on top bit; held 5 cycles each side of the toggle
  task automatic put(input logic trk, input logic [5:0] val, input logic bad);
    logic [6:0] c;
    c = trk ? {2'b00, (~^val[3:0]) ^ bad, val[3:0]} : {(~^val) ^ bad, val};
    @(posedge core_clk);
    head_char <= c;
    head_trk <= trk;
    repeat (5) @(posedge core_clk);
    head_char_tgl <= ~head_char_tgl;
    repeat (5) @(posedge core_clk);
    head_char <= ~c; // Stale value never lingers on the lines
  endtask
  // Track body then check character; bad 1 spoils parity, bad 2 the check
  task automatic track(input logic trk, input logic [5:0] q[$], input int bad);
    logic [5:0] lrc;
    lrc = 6'h00;
    foreach (q[i])
    begin
      lrc = lrc ^ q[i];
      put(trk, q[i], bad == 1 && i == 1);
    end
    if (q.size() != 0)
      put(trk, lrc ^ {5'h00, bad == 2}, 1'b0);
  endtask
  task automatic done_swipe();
    repeat (5) @(posedge core_clk);
    head_swipe_tgl <= ~head_swipe_tgl;
  endtask
endmodule // mstf_head_model
`default_nettype wire

// file: tb/test_magstripe_track_record_formatter.sv
// Self-checking bench for the track record formatter
`include "mstf_defs.vh"
`default_nettype none
module test_magstripe_track_record_formatter;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rec_ready = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic [6:0] head_char;
  wire logic head_trk, head_char_tgl, head_swipe_tgl, rec_valid, retry_lamp, irq;
  wire logic [7:0] rec_data;
  logic [7:0] got[$];
  logic [7:0] none[$];
  logic [5:0] t1q[$] = '{6'h05, 6'h12, 6'h1f};
  logic [7:0] t1r[$] = '{8'h04, 8'h04, 8'h05, 8'h12, 8'h1f};
  logic [31:0] v;
  int n_fail = 0;
  int n_checks = 0;
  always #4 core_clk = ~core_clk;
  // Host stalls every other cycle so held bytes get exercised
  always @(posedge core_clk)
    rec_ready <= ~rec_ready;
  always @(posedge core_clk)
    if (rec_valid === 1'b1 && rec_ready === 1'b1)
      got.push_back(rec_data);
  mstf_formatter dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .head_char(head_char), .head_trk(head_trk), .head_char_tgl(head_char_tgl),
    .head_swipe_tgl(head_swipe_tgl), .rec_valid(rec_valid), .rec_data(rec_data),
    .rec_ready(rec_ready), .retry_lamp(retry_lamp), .irq(irq));
  mstf_head_model head_u (.core_clk(core_clk), .head_char(head_char), .head_trk(head_trk),
    .head_char_tgl(head_char_tgl), .head_swipe_tgl(head_swipe_tgl));
  // ==========================================================
  // Bus cycles, comparisons and the closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait for the byte count, then a quiet spell for strays
  task automatic expect_rec(input logic [7:0] e[$], input string name);
    int k;
    k = 0;
    while (got.size() < e.size() && k < 300)
    begin
      @(posedge core_clk);
      k++;
    end
    repeat (20) @(posedge core_clk);
    chk(got.size(), e.size());
    foreach (e[i])
      if (i < got.size())
        chk(got[i], e[i]);
    got.delete();
    $display("test %0s done", name);
    if (k == 300)
      print_verdict();
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(`MSTF_T1_SENT_OFS, v);
    chk(v, 32'h1f1f0505);
    rd(`MSTF_T2_SENT_OFS, v);
    chk(v, 32'h0c0f0d0b);
    rd(`MSTF_FAILCNT_OFS, v);
    chk(v, 32'h0);
    rd(8'h3c, v);
    chk(v, 32'h0);
    wr(`MSTF_IRQ_ENABLE_OFS, 32'h3);
    wr(`MSTF_CTRL_OFS, 32'h3);
    head_u.track(1'b0, t1q, 0);
    head_u.done_swipe();
    expect_rec(t1r, "single");
    rd(`MSTF_IRQ_STATUS_OFS, v);
    chk(v, 32'h1);
    wr(`MSTF_IRQ_CLEAR_OFS, 32'h1);
    #1 chk(irq, 1'b0);
    wr(`MSTF_CTRL_OFS, 32'h3);
    head_u.track(1'b0, t1q, 1);
    head_u.done_swipe();
    expect_rec(none, "parity fail");
    chk(retry_lamp, 1'b1);
    rd(`MSTF_FAILCNT_OFS, v);
    chk(v, 32'h1);
    head_u.track(1'b0, t1q, 0);
    head_u.done_swipe();
    expect_rec(t1r, "retry");
    chk(retry_lamp, 1'b0);
    wr(`MSTF_CTRL_OFS, 32'h3);
    head_u.track(1'b0, t1q, 2);
    head_u.done_swipe();
    expect_rec(none, "check fail");
    rd(`MSTF_STATUS_OFS, v);
    chk(v, 32'h7);
    wr(`MSTF_CTRL_OFS, 32'h8);
    repeat (2) @(posedge core_clk);
    chk(retry_lamp, 1'b0);
    head_u.track(1'b0, t1q, 0);
    head_u.done_swipe();
    expect_rec(none, "cancel");
    wr(`MSTF_IRQ_ENABLE_OFS, 32'h0);
    #1 chk(irq, 1'b0);
    wr(`MSTF_IRQ_ENABLE_OFS, 32'h2);
    #1 chk(irq, 1'b1);
    wr(`MSTF_IRQ_CLEAR_OFS, 32'h3);
    #1 chk(irq, 1'b0);
    wr(`MSTF_CTRL_OFS, 32'h7);
    head_u.track(1'b0, t1q, 0);
    head_u.track(1'b1, '{6'h0d, 6'h03, 6'h0c}, 0);
    head_u.done_swipe();
    expect_rec('{8'h04, 8'h04, 8'h05, 8'h12, 8'h1f, 8'h04, 8'h02, 8'h0d, 8'h03, 8'h0c},
      "two tracks");
    wr(`MSTF_CTRL_OFS, 32'h7);
    head_u.track(1'b0, t1q, 0);
    head_u.track(1'b1, '{6'h0b, 6'h05, 6'h0f}, 2);
    head_u.done_swipe();
    expect_rec(none, "all tracks fail");
    chk(retry_lamp, 1'b1);
    wr(`MSTF_CTRL_OFS, 32'h8);
    wr(`MSTF_CONFIG_OFS, 32'h1);
    rd(`MSTF_CONFIG_OFS, v);
    chk(v, 32'h1);
    wr(`MSTF_CTRL_OFS, 32'h7);
    head_u.track(1'b0, t1q, 2);
    head_u.track(1'b1, '{6'h0b, 6'h05, 6'h0f}, 0);
    head_u.done_swipe();
    expect_rec('{8'h01, 8'h44, 8'h04, 8'h02, 8'h0b, 8'h05, 8'h0f}, "any one");
    wr(`MSTF_CTRL_OFS, 32'h7);
    head_u.track(1'b0, t1q, 0);
    head_u.done_swipe();
    expect_rec('{8'h04, 8'h04, 8'h05, 8'h12, 8'h1f, 8'h01, 8'h82}, "blank");
    rd(`MSTF_FAILCNT_OFS, v);
    chk(v, 32'h3);
    print_verdict();
  end
endmodule // test_magstripe_track_record_formatter
`default_nettype wire
